// >>> include/mcc_pkg.sv
// Constants and types for the many-to-one core concentrator
// Behaviour
// - Data flows only senders to one receiver
// - Hardware arbiter grants requesters in round robin
// - Shared FIFO depth defaults to 64 entries
// - Sender count is a parameter, default 3
// - Build option selects software arbitration, default off
// - Software grant register names sole pushing sender
// - Each sender has unique identifier, default its own index
// - Receiver status: entries reach size-check value
// - Receiver status empty when entries below size-check
// - Size-check registers are write-only, status only
// - Pop read returns and removes oldest entry
// - Peek read returns head without removing it
// - Header low 9 bits hold sender identifier
// - Header upper bits hold message length
// - Sender status: free space meets size-check value
// - Push write appends word while sender granted
// - Sender request flag tells arbiter message waits
// - Ungranted sender status reads not-granted code
// - Granted, too little space: buffer-full code
// - Granted, enough space: buffer-available code
package mcc_pkg;

  localparam int WORD_W  = 18;
  localparam int ID_W    = 9;
  localparam int DEPTH   = 64;
  localparam int CNT_W   = 7;
  localparam int PTR_W   = 6;
  localparam int SENDERS = 3;
  localparam int IDX_W   = 2;

  // Sender i carries identifier i unless overridden
  localparam logic [SENDERS*ID_W-1:0] DEFAULT_IDS = {9'h002, 9'h001, 9'h000};

  // Byte offsets, receiver window
  localparam logic [7:0] RX_STATUS = 8'h00;
  localparam logic [7:0] RX_SIZE   = 8'h04;
  localparam logic [7:0] RX_POP    = 8'h08;
  localparam logic [7:0] RX_PEEK   = 8'h0C;
  localparam logic [7:0] RX_GRANT  = 8'h10;

  // Sender windows: base plus index times stride
  localparam logic [7:0] SND_BASE   = 8'h20;
  localparam int         SND_SHIFT  = 4;
  localparam logic [3:0] SND_STATUS = 4'h0;
  localparam logic [3:0] SND_SIZE   = 4'h4;
  localparam logic [3:0] SND_PUSH   = 4'h8;
  localparam logic [3:0] SND_REQ    = 4'hC;

  // Status codes
  localparam logic [WORD_W-1:0] CODE_AVAILABLE   = 18'h00000;
  localparam logic [WORD_W-1:0] CODE_EMPTY       = 18'h00001;
  localparam logic [WORD_W-1:0] CODE_FULL        = 18'h00002;
  localparam logic [WORD_W-1:0] CODE_NOT_GRANTED = 18'h00003;

  // Reset values
  localparam logic [WORD_W-1:0] SIZE_RESET  = 18'h00001;
  localparam logic [ID_W-1:0]   GRANT_RESET = 9'h000;

  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } mcc_dphase_s;

  typedef struct packed {
    logic             valid;
    logic [IDX_W-1:0] idx;
  } mcc_grant_s;

endpackage

// >>> rtl/mcc_fifo.sv
// Shared message FIFO of the concentrator
`timescale 1ns/10ps
`default_nettype none
module mcc_fifo (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       arst_n,
  // Fill side
  input  wire logic                       push,
  input  wire logic [mcc_pkg::WORD_W-1:0] push_data,
  // Drain side
  input  wire logic                       pop,
  output logic      [mcc_pkg::WORD_W-1:0] head,
  output logic      [mcc_pkg::CNT_W-1:0]  count
);

  logic [mcc_pkg::WORD_W-1:0] mem [mcc_pkg::DEPTH];
  logic [mcc_pkg::PTR_W-1:0]  wr_ptr;
  logic [mcc_pkg::PTR_W-1:0]  rd_ptr;
  logic                       do_push;
  logic                       do_pop;

  // Guard here too, so a caller slip cannot corrupt pointers
  assign do_push = push && (count != mcc_pkg::CNT_W'(mcc_pkg::DEPTH));
  assign do_pop  = pop && (count != '0);
  assign head    = mem[rd_ptr];

  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (do_push && !do_pop) begin
      count <= count + 1'b1;
    end else if (do_pop && !do_push) begin
      count <= count - 1'b1;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/mcc_arbiter.sv
// Sender arbiter: round robin or software-selected grant
`timescale 1ns/10ps
`default_nettype none
module mcc_arbiter #(
  parameter logic [mcc_pkg::SENDERS*mcc_pkg::ID_W-1:0] SENDER_IDS = mcc_pkg::DEFAULT_IDS,
  parameter bit                                        SOFT_ARB   = 1'b0
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       arst_n,
  // Requests and software choice
  input  wire logic [mcc_pkg::SENDERS-1:0] req,
  input  wire logic [mcc_pkg::ID_W-1:0]    soft_id,
  // Grant
  output var mcc_pkg::mcc_grant_s          grant
);

  mcc_pkg::mcc_grant_s next_grant;
  logic                found;
  int                  cand;

  always_comb begin
    next_grant = '0;
    found      = 1'b0;
    cand       = 0;
    if (SOFT_ARB) begin
      for (int i = 0; i < mcc_pkg::SENDERS; i++) begin
        if (!found && SENDER_IDS[i*mcc_pkg::ID_W +: mcc_pkg::ID_W] == soft_id) begin
          found      = 1'b1;
          next_grant = '{valid: 1'b1, idx: mcc_pkg::IDX_W'(i)};
        end
      end
    end else if (grant.valid && req[grant.idx]) begin
      next_grant = grant;
    end else begin
      for (int i = 1; i <= mcc_pkg::SENDERS; i++) begin
        cand = (int'(grant.idx) + i) % mcc_pkg::SENDERS;
        if (!found && req[cand]) begin
          found      = 1'b1;
          next_grant = '{valid: 1'b1, idx: mcc_pkg::IDX_W'(cand)};
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      grant <= '0;
    end else begin
      grant <= next_grant;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/mcc_concentrator.sv
// Concentrator top: AHB-Lite register slave, FIFO and arbiter
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module mcc_concentrator #(
  parameter logic [mcc_pkg::SENDERS*mcc_pkg::ID_W-1:0] SENDER_IDS = mcc_pkg::DEFAULT_IDS,
  parameter bit                                        SOFT_ARB   = 1'b0
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp
);

  localparam int SN = mcc_pkg::SENDERS;
  localparam int WW = mcc_pkg::WORD_W;

  mcc_pkg::mcc_dphase_s dph;
  mcc_pkg::mcc_grant_s  grant;
  mcc_pkg::mcc_grant_s  grant_q;
  logic                 accept;
  logic [WW-1:0]        rx_size;
  logic [WW-1:0]        snd_size [SN];
  logic [SN-1:0]        req;
  logic [SN-1:0]        req_q;
  logic [mcc_pkg::ID_W-1:0] soft_id;
  logic                 hdr_pending;
  logic                 is_rx;
  logic [7:0]           snd_off;
  logic [3:0]           sidx;
  logic                 snd_hit;
  logic [3:0]           sreg;
  logic                 wr;
  logic                 rd;
  logic                 pop;
  logic                 push;
  logic [WW-1:0]        push_data;
  logic [WW-1:0]        head;
  logic [mcc_pkg::CNT_W-1:0] count;
  logic [WW-1:0]        fill;
  logic [WW-1:0]        room;
  logic [WW-1:0]        rdval;
  logic                 granted_here;
  logic [mcc_pkg::ID_W-1:0] grant_id;

  // Address phase taken only when the bus is ready
  assign accept  = hsel && htrans[1] && hready;
  assign wr      = dph.valid && dph.write;
  assign rd      = dph.valid && !dph.write;
  assign is_rx   = dph.addr < mcc_pkg::SND_BASE;
  assign snd_off = dph.addr - mcc_pkg::SND_BASE;
  assign sidx    = snd_off[7:mcc_pkg::SND_SHIFT];
  assign snd_hit = !is_rx && (sidx < 4'(SN));
  assign sreg    = dph.addr[3:0];
  assign fill    = WW'(count);
  assign room    = WW'(mcc_pkg::DEPTH) - WW'(count);
  assign grant_id = SENDER_IDS[grant.idx*mcc_pkg::ID_W +: mcc_pkg::ID_W];
  assign granted_here = grant.valid && (grant.idx == sidx[mcc_pkg::IDX_W-1:0]);

  assign pop = rd && is_rx && (dph.addr == mcc_pkg::RX_POP) && (count != '0);

  assign push = wr && snd_hit && (sreg == mcc_pkg::SND_PUSH) && granted_here
                && (count != mcc_pkg::CNT_W'(mcc_pkg::DEPTH));

  // Hardware stamps the identifier into the header
  // Length bits pass from software unchanged
  assign push_data = hdr_pending ? {hwdata[WW-1:mcc_pkg::ID_W], grant_id} : hwdata[WW-1:0];

  // Bus handshake: one wait state, read data from a flop
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dph       <= '0;
      hreadyout <= 1'b1;
    end else if (accept) begin
      dph       <= '{valid: 1'b1, write: hwrite, addr: haddr[7:0]};
      hreadyout <= 1'b0;
    end else if (dph.valid) begin
      dph.valid <= 1'b0;
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= '0;
    end else if (rd) begin
      hrdata <= {14'h0000, rdval};
    end
  end

  // Errors are never signalled
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_size <= mcc_pkg::SIZE_RESET;
    end else if (wr && is_rx && dph.addr == mcc_pkg::RX_SIZE) begin
      rx_size <= hwdata[WW-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_id <= mcc_pkg::GRANT_RESET;
    end else if (wr && is_rx && dph.addr == mcc_pkg::RX_GRANT) begin
      soft_id <= hwdata[mcc_pkg::ID_W-1:0];
    end
  end

  for (genvar s = 0; s < SN; s++) begin : g_snd
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        snd_size[s] <= mcc_pkg::SIZE_RESET;
      end else if (wr && snd_hit && sidx == 4'(s) && sreg == mcc_pkg::SND_SIZE) begin
        snd_size[s] <= hwdata[WW-1:0];
      end
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        req[s] <= 1'b0;
      end else if (wr && snd_hit && sidx == 4'(s) && sreg == mcc_pkg::SND_REQ) begin
        req[s] <= hwdata[0];
      end
    end
  end

  // New grant or fresh request means next push is a header
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      grant_q     <= '0;
      req_q       <= '0;
      hdr_pending <= 1'b1;
    end else begin
      grant_q <= grant;
      req_q   <= req;
      if (grant != grant_q || (grant.valid && req[grant.idx] && !req_q[grant.idx])) begin
        hdr_pending <= 1'b1;
      end else if (push) begin
        hdr_pending <= 1'b0;
      end
    end
  end

  always_comb begin
    rdval = '0;
    if (is_rx) begin
      case (dph.addr)
        mcc_pkg::RX_STATUS: begin
          rdval = (fill >= rx_size) ? mcc_pkg::CODE_AVAILABLE : mcc_pkg::CODE_EMPTY;
        end
        mcc_pkg::RX_POP: begin
          rdval = (count != '0) ? head : '0;
        end
        mcc_pkg::RX_PEEK: begin
          rdval = (count != '0) ? head : '0;
        end
        mcc_pkg::RX_GRANT: begin
          rdval = WW'(soft_id);
        end
        default: begin
          rdval = '0;
        end
      endcase
    end else if (snd_hit) begin
      case (sreg)
        mcc_pkg::SND_STATUS: begin
          if (!granted_here) begin
            rdval = mcc_pkg::CODE_NOT_GRANTED;
          end else if (room >= snd_size[sidx[mcc_pkg::IDX_W-1:0]]) begin
            rdval = mcc_pkg::CODE_AVAILABLE;
          end else begin
            rdval = mcc_pkg::CODE_FULL;
          end
        end
        mcc_pkg::SND_REQ: begin
          rdval = WW'(req[sidx[mcc_pkg::IDX_W-1:0]]);
        end
        default: begin
          rdval = '0;
        end
      endcase
    end
  end

  mcc_arbiter #(
    .SENDER_IDS (SENDER_IDS),
    .SOFT_ARB   (SOFT_ARB)
  ) u_arbiter (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .req     (req),
    .soft_id (soft_id),
    .grant   (grant)
  );

  // Single shared queue toward the receiver
  mcc_fifo u_fifo (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .push      (push),
    .push_data (push_data),
    .pop       (pop),
    .head      (head),
    .count     (count)
  );

endmodule
`default_nettype wire

// >>> bench/mcc_checker.sv
// Bus-side checks of the concentrator register slave
`timescale 1ns/10ps
`default_nettype none
module mcc_checker (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        arst_n,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic rd;
  logic snd;
  assign rd  = hsel && htrans[1] && hready && !hwrite;
  assign snd = haddr[7:4] inside {4'h2, 4'h3, 4'h4};

  wait_one_a: assert property (
    hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
    else $error("wait state not one cycle");
  rdata_hold_a: assert property ($past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved without a read");
  word_width_a: assert property (hrdata[31:18] == 14'h0)
    else $error("read data wider than a word");
  rx_status_a: assert property (
    rd && haddr[7:0] == mcc_pkg::RX_STATUS |=> ##1 hrdata <= 32'h1)
    else $error("receiver status code out of set");
  tx_status_a: assert property (
    rd && snd && haddr[3:0] == mcc_pkg::SND_STATUS |=> ##1 hrdata <= 32'h3)
    else $error("sender status code out of set");
  size_wo_a: assert property (
    rd && haddr[7:0] == mcc_pkg::RX_SIZE |=> ##1 hrdata == 32'h0)
    else $error("size check readable");
  req_bit_a: assert property (
    rd && snd && haddr[3:0] == mcc_pkg::SND_REQ |=> ##1 hrdata[31:1] == 31'h0)
    else $error("request flag wider than one bit");
  grant_w_a: assert property (
    rd && haddr[7:0] == mcc_pkg::RX_GRANT |=> ##1 hrdata[31:9] == 23'h0)
    else $error("grant select wider than an id");
  resp_okay_a: assert property (!hresp)
    else $error("error response on the bus");
endmodule
`default_nettype wire

// >>> bench/mcc_core_model.sv
// Core software model: bus master for sender and receiver cores
`timescale 1ns/10ps
`default_nettype none
module mcc_core_model (
  // Clock
  input  wire logic        sys_clk,
  // AHB-Lite master
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = mcc_pkg::HTRANS_IDLE;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  function automatic logic [7:0] sa(input int k, input logic [3:0] off);
    return mcc_pkg::SND_BASE + 8'(k * 16) + {4'h0, off};
  endfunction

  // Taken at the rising edge, before the slave's flops move
  task automatic wait_rdy(output logic [31:0] q);
    do begin
      @(posedge sys_clk);
    end while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= mcc_pkg::HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    wait_rdy(q);
    htrans <= mcc_pkg::HTRANS_IDLE;
    hwdata <= d;
    wait_rdy(q);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, ~hwdata, q);
  endtask

  task automatic send(input int k, input int n, input logic [17:0] d0);
    logic [31:0] q;
    wr(sa(k, mcc_pkg::SND_SIZE), 32'(n + 1));
    wr(sa(k, mcc_pkg::SND_REQ), 32'h1);
    do rd(sa(k, mcc_pkg::SND_STATUS), q);
    while (q === {14'h0, mcc_pkg::CODE_NOT_GRANTED});
    wr(sa(k, mcc_pkg::SND_PUSH), {14'h0, 9'(n), 9'(k)});
    for (int i = 0; i < n; i++)
      wr(sa(k, mcc_pkg::SND_PUSH), {14'h0, d0 + 18'(i)});
  endtask

  task automatic rel(input int k);
    wr(sa(k, mcc_pkg::SND_REQ), 32'h0);
  endtask
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Testbench top for the concentrator
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        sys_clk;
  logic        arst_n;
  logic        hsel;
  logic        hwrite;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hsel_s;
  logic        hwrite_s;
  logic        hreadyout_s;
  logic        hresp_s;
  logic [1:0]  htrans_s;
  logic [2:0]  hsize_s;
  logic [31:0] haddr_s;
  logic [31:0] hwdata_s;
  logic [31:0] hrdata_s;
  int          n_fail;
  int          cmp_count;

  mcc_concentrator dut (.sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
  mcc_core_model m (.sys_clk(sys_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
  // Second copy with the software-chosen grant
  mcc_concentrator #(.SOFT_ARB(1'b1)) dut_s (.sys_clk(sys_clk), .arst_n(arst_n),
    .hsel(hsel_s), .haddr(haddr_s), .htrans(htrans_s), .hwrite(hwrite_s), .hsize(hsize_s),
    .hwdata(hwdata_s), .hready(hreadyout_s), .hreadyout(hreadyout_s), .hrdata(hrdata_s),
    .hresp(hresp_s));
  mcc_core_model m_s (.sys_clk(sys_clk), .hsel(hsel_s), .haddr(haddr_s), .htrans(htrans_s),
    .hwrite(hwrite_s), .hsize(hsize_s), .hwdata(hwdata_s), .hready(hreadyout_s),
    .hrdata(hrdata_s));

  function automatic logic [31:0] hdr(input int n, input int k);
    return {14'h0, 9'(n), mcc_pkg::DEFAULT_IDS[k*9 +: 9]};
  endfunction

  // Reads through the round robin copy, or the software-grant copy when sw is set
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e,
                      input bit sw = 1'b0);
    logic [31:0] q;
    if (sw) begin
      m_s.rd(a, q);
    end else begin
      m.rd(a, q);
    end
    cmp_count++;
    if (q !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, q);
    end
  endtask

  task automatic t_idle();
    rchk("rx status", mcc_pkg::RX_STATUS, 32'(mcc_pkg::CODE_EMPTY));
    rchk("s0 status", m.sa(0, 4'h0), 32'(mcc_pkg::CODE_NOT_GRANTED));
    rchk("size read", mcc_pkg::RX_SIZE, 32'h0);
    rchk("unmapped", 8'hFC, 32'h0);
    m.wr(mcc_pkg::RX_GRANT, 32'h1FF);
    rchk("grant sel", mcc_pkg::RX_GRANT, 32'h1FF);
    m.wr(mcc_pkg::RX_GRANT, 32'h0);
  endtask

  task automatic t_msg();
    m.send(1, 3, 18'h100);
    m.wr(mcc_pkg::RX_SIZE, 32'h5);
    rchk("rx short", mcc_pkg::RX_STATUS, 32'(mcc_pkg::CODE_EMPTY));
    m.wr(mcc_pkg::RX_SIZE, 32'h4);
    rchk("rx whole", mcc_pkg::RX_STATUS, 32'(mcc_pkg::CODE_AVAILABLE));
    rchk("peek", mcc_pkg::RX_PEEK, hdr(3, 1));
    rchk("peek again", mcc_pkg::RX_PEEK, hdr(3, 1));
    rchk("header", mcc_pkg::RX_POP, hdr(3, 1));
    for (int i = 0; i < 3; i++)
      rchk("data", mcc_pkg::RX_POP, 32'h100 + 32'(i));
    m.rel(1);
    m.wr(mcc_pkg::RX_SIZE, 32'h1);
    rchk("rx drained", mcc_pkg::RX_STATUS, 32'(mcc_pkg::CODE_EMPTY));
  endtask

  // s0 asks again while s1 holds: round robin must serve s2 before s0
  task automatic t_rr();
    m.wr(m.sa(0, 4'hC), 32'h1);
    m.wr(m.sa(2, 4'hC), 32'h1);
    m.wr(m.sa(1, 4'hC), 32'h1);
    rchk("s1 req flag", m.sa(1, 4'hC), 32'h1);
    rchk("s2 held off", m.sa(2, 4'h0), 32'(mcc_pkg::CODE_NOT_GRANTED));
    m.wr(m.sa(2, 4'h8), 32'h3AA);
    m.rel(0);
    rchk("s1 next", m.sa(1, 4'h0), 32'(mcc_pkg::CODE_AVAILABLE));
    rchk("s2 waits", m.sa(2, 4'h0), 32'(mcc_pkg::CODE_NOT_GRANTED));
    m.wr(m.sa(0, 4'hC), 32'h1);
    m.rel(1);
    rchk("s2 before s0", m.sa(2, 4'h0), 32'(mcc_pkg::CODE_AVAILABLE));
    rchk("s0 after s2", m.sa(0, 4'h0), 32'(mcc_pkg::CODE_NOT_GRANTED));
    m.rel(2);
    rchk("s0 wraps", m.sa(0, 4'h0), 32'(mcc_pkg::CODE_AVAILABLE));
    m.rel(0);
    rchk("no drop in", mcc_pkg::RX_STATUS, 32'(mcc_pkg::CODE_EMPTY));
  endtask

  task automatic t_fill();
    m.send(0, 59, 18'h200);
    m.wr(m.sa(0, 4'h4), 32'h5);
    rchk("s0 full", m.sa(0, 4'h0), 32'(mcc_pkg::CODE_FULL));
    m.wr(m.sa(0, 4'h4), 32'h4);
    rchk("s0 room", m.sa(0, 4'h0), 32'(mcc_pkg::CODE_AVAILABLE));
    m.wr(mcc_pkg::RX_SIZE, 32'd60);
    rchk("rx 60", mcc_pkg::RX_STATUS, 32'(mcc_pkg::CODE_AVAILABLE));
    m.wr(mcc_pkg::RX_SIZE, 32'd61);
    rchk("rx 61", mcc_pkg::RX_STATUS, 32'(mcc_pkg::CODE_EMPTY));
    m.rel(0);
    rchk("big header", mcc_pkg::RX_POP, hdr(59, 0));
    for (int i = 0; i < 59; i++)
      rchk("big data", mcc_pkg::RX_POP, 32'h200 + 32'(i));
  endtask

  // Software grant: id 0 holds from reset, then id 2 is chosen without any request
  task automatic t_soft();
    rchk("sw s0 granted", m.sa(0, 4'h0), 32'(mcc_pkg::CODE_AVAILABLE), 1'b1);
    rchk("sw s2 idle", m.sa(2, 4'h0), 32'(mcc_pkg::CODE_NOT_GRANTED), 1'b1);
    m_s.wr(mcc_pkg::RX_GRANT, 32'h2);
    rchk("sw s2 chosen", m.sa(2, 4'h0), 32'(mcc_pkg::CODE_AVAILABLE), 1'b1);
    rchk("sw s0 dropped", m.sa(0, 4'h0), 32'(mcc_pkg::CODE_NOT_GRANTED), 1'b1);
    m_s.wr(m.sa(0, 4'h8), 32'h3AA);
    m_s.send(2, 1, 18'h155);
    rchk("sw header", mcc_pkg::RX_POP, hdr(1, 2), 1'b1);
    rchk("sw data", mcc_pkg::RX_POP, 32'h155, 1'b1);
    rchk("sw drained", mcc_pkg::RX_STATUS, 32'(mcc_pkg::CODE_EMPTY), 1'b1);
    m_s.rel(2);
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Whole run is well under a thousand bus cycles
  initial begin
    #2_000_000;
    n_fail++;
    final_report();
  end

  initial begin
    n_fail    = 0;
    cmp_count = 0;
    arst_n    = 1'b0;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_idle();
    t_msg();
    t_rr();
    t_fill();
    t_soft();
    final_report();
  end
endmodule

bind mcc_concentrator mcc_checker chk_i (.sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
`default_nettype wire
